// ### alu_status_flags_tb_top.sv
// Purpose: Self-checking bench for the ALU status word block
// Assumes: Ack one cycle after request; flags land on the edge after valid
// Notes: Level output moves on the same edge as the status word
module alu_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 0, i_rst = 1, cyc = 0, stb = 0, we = 0, va = 0, ci = 0, byt = 0, rb = 0;
  logic [3:0] adr = 4'h0, sel = 4'h3;
  logic [31:0] dat = 32'h0, wb_dat_o, q;
  logic [4:0] upd = 5'h00;
  logic [15:0] aa = 16'h0000, bb = 16'h0000, o_status_word;
  logic [3:0] o_priority_level;
  logic wb_ack_o, o_user_irq_masked;
  int err_count = 0, total_checks = 0;
  asf_status u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .i_alu_valid(va), .i_alu_update(upd), .i_alu_a(aa), .i_alu_b(bb),
    .i_alu_cin(ci), .i_alu_byte(byt), .i_repeat_busy(rb), .o_status_word(o_status_word),
    .o_priority_level(o_priority_level), .o_user_irq_masked(o_user_irq_masked));
  always #2 i_ref_clk = ~i_ref_clk;
  // ==========================================================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      chk({31'h0, wb_ack_o}, 32'h1);
      summarize();
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic alu(input logic [15:0] a, b, input logic c, by, input logic [4:0] u,
                     input logic [15:0] exp);
    @(posedge i_ref_clk);
    va <= 1'b1;
    upd <= u;
    aa <= a;
    bb <= b;
    ci <= c;
    byt <= by;
    @(posedge i_ref_clk);
    va <= 1'b0;
    #1 chk({16'h0000, o_status_word & 16'h010F}, {16'h0000, exp});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_map();
    wb(1'b0, asf_pkg::ASF_ADDR_STATUS, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 4'hC, 32'h0000FFFF);
    wb(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, asf_pkg::ASF_ADDR_STATUS, 32'h0);
    chk(q, 32'h0);
    $display("test reset_map done");
  endtask
  task automatic t_prio();
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, asf_pkg::ASF_ADDR_CORE_CTRL, 32'(e << 3));
      wb(1'b0, asf_pkg::ASF_ADDR_CORE_CTRL, 32'h0);
      chk(q, 32'(e << 3));
      for (int p = 0; p < 8; p++) begin
        wb(1'b1, asf_pkg::ASF_ADDR_STATUS, 32'(p << 5));
        @(posedge i_ref_clk);
        #1 chk({28'h0, o_priority_level}, 32'(p + 8 * e));
        chk({31'h0, o_user_irq_masked}, {31'h0, p == 7});
        wb(1'b0, asf_pkg::ASF_ADDR_LEVEL, 32'h0);
        chk(q, 32'(p + 8 * e));
      end
    end
    $display("test prio done");
  endtask
  // Entered with level 15 and masking on, so a missed clear shows
  task automatic t_reset_mid();
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1 chk({11'h000, o_user_irq_masked, o_priority_level, o_status_word}, 32'h0);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    wb(1'b0, asf_pkg::ASF_ADDR_CORE_CTRL, 32'h0);
    chk(q, 32'h0);
    $display("test reset_mid done");
  endtask
  task automatic t_repeat();
    wb(1'b1, asf_pkg::ASF_ADDR_STATUS, 32'h00000010);
    #1 chk({31'h0, o_status_word[4]}, 32'h0);
    @(posedge i_ref_clk);
    rb <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1 chk({31'h0, o_status_word[4]}, 32'h1);
    wb(1'b1, asf_pkg::ASF_ADDR_STATUS, 32'h0);
    #1 chk({31'h0, o_status_word[4]}, 32'h1);
    @(posedge i_ref_clk);
    rb <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 chk({31'h0, o_status_word[4]}, 32'h0);
    $display("test repeat done");
  endtask
  task automatic t_alu();
    alu(16'h7FFF, 16'h0001, 1'b0, 1'b0, 5'h1F, 16'h010C);
    alu(16'hFFFF, 16'h0001, 1'b0, 1'b0, 5'h1F, 16'h0103);
    alu(16'h0001, 16'h0002, 1'b0, 1'b0, 5'h1F, 16'h0000);
    alu(16'h000F, 16'h0001, 1'b0, 1'b1, 5'h1F, 16'h0100);
    alu(16'hFFFF, 16'h0001, 1'b0, 1'b0, 5'h01, 16'h0101);
    $display("test alu done");
  endtask
  // ALU carry update and a software write land on the same edge; the ALU wins
  task automatic t_collide();
    fork
      wb(1'b1, asf_pkg::ASF_ADDR_STATUS, 32'h00000101);
      begin
        @(posedge i_ref_clk);
        va <= 1'b1;
        upd <= 5'h01;
        aa <= 16'h0001;
        bb <= 16'h0002;
        ci <= 1'b0;
        byt <= 1'b0;
        @(posedge i_ref_clk);
        va <= 1'b0;
      end
    join
    wb(1'b0, asf_pkg::ASF_ADDR_STATUS, 32'h0);
    chk(q, 32'h00000100);
    $display("test collide done");
  endtask
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset_map();
    t_prio();
    t_reset_mid();
    t_repeat();
    t_alu();
    t_collide();
    summarize();
  end
endmodule

// ### asf_flag_calc.sv
// Purpose: Derives ALU result flags from operands and result
// Assumes: Addition view; subtract callers pass inverted operand b
// Notes: Purely combinational
module asf_flag_calc (
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  input wire logic i_cin,
  input wire logic i_byte,
  output logic o_c,
  output logic o_z,
  output logic o_ov,
  output logic o_n,
  output logic o_dc
);
  logic [16:0] sum_w;
  logic [8:0] sum_b;
  logic [4:0] nib;
  logic [8:0] low8;
  always_comb begin
    sum_w = {1'b0, i_a} + {1'b0, i_b} + {16'h0000, i_cin};
    sum_b = {1'b0, i_a[7:0]} + {1'b0, i_b[7:0]} + {8'h00, i_cin};
    nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
    low8 = sum_b;
    if (i_byte) begin
      o_c = sum_b[8];
      o_z = (sum_b[7:0] == 8'h00);
      o_n = sum_b[7];
      o_ov = (i_a[7] == i_b[7]) && (sum_b[7] != i_a[7]);
      o_dc = nib[4];
    end else begin
      o_c = sum_w[16];
      o_z = (sum_w[15:0] == 16'h0000);
      o_n = sum_w[15];
      o_ov = (i_a[15] == i_b[15]) && (sum_w[15] != i_a[15]);
      o_dc = low8[8];
    end
  end
endmodule

// ### asf_pkg.sv
// Purpose: Constants for the ALU status word block
// Assumes: 16-bit data path, Wishbone slave with 32-bit data
// Notes: Register byte offsets chosen locally
package asf_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] ASF_ADDR_STATUS = 4'h0;
  localparam logic [3:0] ASF_ADDR_CORE_CTRL = 4'h4;
  localparam logic [3:0] ASF_ADDR_LEVEL = 4'h8;
  // ==========================================================
  // Status word fields and masks; ASF_BIT_EXT is bit 3 of the core control word
  localparam int ASF_BIT_CARRY = 0;
  localparam int ASF_BIT_ZERO = 1;
  localparam int ASF_BIT_OVF = 2;
  localparam int ASF_BIT_NEG = 3;
  localparam int ASF_BIT_RPT = 4;
  localparam int ASF_BIT_PRI_LO = 5;
  localparam int ASF_BIT_PRI_HI = 7;
  localparam int ASF_BIT_HALF = 8;
  localparam int ASF_BIT_EXT = 3;
  localparam logic [15:0] ASF_STATUS_RESET = 16'h0000;
  localparam logic [15:0] ASF_STATUS_WMASK = 16'h01EF;
  localparam logic [15:0] ASF_STATUS_RMASK = 16'h01FF;
  localparam logic [2:0] ASF_PRI_MASKED = 3'h7;
  localparam logic [3:0] ASF_PRI_EXT_ADD = 4'h8;
  // ==========================================================
  // ALU flag update selectors (which flags an operation affects)
  localparam int ASF_UPD_C = 0;
  localparam int ASF_UPD_Z = 1;
  localparam int ASF_UPD_OV = 2;
  localparam int ASF_UPD_N = 3;
  localparam int ASF_UPD_DC = 4;
endpackage

// ### asf_status.sv
// Purpose: ALU status word with priority level and Wishbone access
// Assumes: Single clock, async active-high reset
// Notes: Ack one cycle after strobe; unmapped reads return zero
// Functional notes
// - Three-bit priority field gives current level; all ones is level 7, masks users
// - Extension bit in core control word adds eight to the level
// - Repeat-active flag at bit 4 is read-only, high during repeat loops
// - Carry flag at bit 0 follows carry out of result MSB
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
module asf_status (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic i_alu_valid,
  input wire logic [4:0] i_alu_update,
  input wire logic [15:0] i_alu_a,
  input wire logic [15:0] i_alu_b,
  input wire logic i_alu_cin,
  input wire logic i_alu_byte,
  input wire logic i_repeat_busy,
  output logic [15:0] o_status_word,
  output logic [3:0] o_priority_level,
  output logic o_user_irq_masked
);
  // ==========================================================
  // State
  logic [15:0] status_ff, nxt_status;
  logic ext_ff, nxt_ext;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [3:0] lvl_ff, nxt_lvl;
  logic msk_ff, nxt_msk;
  logic f_c, f_z, f_ov, f_n, f_dc;
  logic wr_req, rd_req;

  asf_flag_calc u_calc (
    .i_a(i_alu_a),
    .i_b(i_alu_b),
    .i_cin(i_alu_cin),
    .i_byte(i_alu_byte),
    .o_c(f_c),
    .o_z(f_z),
    .o_ov(f_ov),
    .o_n(f_n),
    .o_dc(f_dc)
  );

  function automatic logic [3:0] level_of(input logic [15:0] sw, input logic ext);
    level_of = {1'b0, sw[asf_pkg::ASF_BIT_PRI_HI:asf_pkg::ASF_BIT_PRI_LO]}
             + (ext ? asf_pkg::ASF_PRI_EXT_ADD : 4'h0);
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_status = status_ff;
    nxt_ext = ext_ff;
    nxt_ack = 1'b0;
    nxt_rdat = 32'h0000_0000;
    wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
    rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
    if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      nxt_ack = 1'b1;
    end
    // Software write first so a same-cycle ALU update wins
    if (wr_req && wb_adr_i == asf_pkg::ASF_ADDR_STATUS) begin
      if (wb_sel_i[0]) begin
        nxt_status[7:0] = (wb_dat_i[7:0] & asf_pkg::ASF_STATUS_WMASK[7:0])
                        | (status_ff[7:0] & ~asf_pkg::ASF_STATUS_WMASK[7:0]);
      end
      if (wb_sel_i[1]) begin
        nxt_status[15:8] = wb_dat_i[15:8] & asf_pkg::ASF_STATUS_WMASK[15:8];
      end
    end
    if (wr_req && wb_adr_i == asf_pkg::ASF_ADDR_CORE_CTRL && wb_sel_i[0]) begin
      nxt_ext = wb_dat_i[asf_pkg::ASF_BIT_EXT];
    end
    if (i_alu_valid) begin
      if (i_alu_update[asf_pkg::ASF_UPD_C]) nxt_status[asf_pkg::ASF_BIT_CARRY] = f_c;
      if (i_alu_update[asf_pkg::ASF_UPD_N]) nxt_status[asf_pkg::ASF_BIT_NEG] = f_n;
      if (i_alu_update[asf_pkg::ASF_UPD_Z]) nxt_status[asf_pkg::ASF_BIT_ZERO] = f_z;
      if (i_alu_update[asf_pkg::ASF_UPD_OV]) nxt_status[asf_pkg::ASF_BIT_OVF] = f_ov;
      if (i_alu_update[asf_pkg::ASF_UPD_DC]) nxt_status[asf_pkg::ASF_BIT_HALF] = f_dc;
    end
    // Hardware-owned bit, software value discarded
    nxt_status[asf_pkg::ASF_BIT_RPT] = i_repeat_busy;
    nxt_status = nxt_status & asf_pkg::ASF_STATUS_RMASK;
    nxt_lvl = level_of(nxt_status, nxt_ext);
    nxt_msk = (nxt_status[asf_pkg::ASF_BIT_PRI_HI:asf_pkg::ASF_BIT_PRI_LO]
               == asf_pkg::ASF_PRI_MASKED);
    if (rd_req) begin
      unique case (wb_adr_i)
        asf_pkg::ASF_ADDR_STATUS: nxt_rdat = {16'h0000, status_ff};
        asf_pkg::ASF_ADDR_CORE_CTRL: nxt_rdat = {28'h0000000, ext_ff, 3'h0};
        asf_pkg::ASF_ADDR_LEVEL: nxt_rdat = {28'h0000000, lvl_ff};
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      status_ff <= asf_pkg::ASF_STATUS_RESET;
      ext_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
      lvl_ff <= 4'h0;
      msk_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      ext_ff <= nxt_ext;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      lvl_ff <= nxt_lvl;
      msk_ff <= nxt_msk;
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign o_status_word = status_ff;
  assign o_priority_level = lvl_ff;
  assign o_user_irq_masked = msk_ff;

  // ==========================================================
  // Checks
  // Concatenation, not addition, so this does not mirror level_of
  property p_level_map;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_priority_level
      == {ext_ff, o_status_word[asf_pkg::ASF_BIT_PRI_HI:asf_pkg::ASF_BIT_PRI_LO]};
  endproperty
  a_level_map: assert property (p_level_map) else $error("level mismatch");

  property p_mask7;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_user_irq_masked
      == (o_status_word[asf_pkg::ASF_BIT_PRI_HI:asf_pkg::ASF_BIT_PRI_LO]
          == asf_pkg::ASF_PRI_MASKED);
  endproperty
  a_mask7: assert property (p_mask7) else $error("mask wrong");

  property p_pri_write;
    @(posedge i_ref_clk) disable iff (i_rst)
    (wr_req && wb_adr_i == asf_pkg::ASF_ADDR_STATUS && wb_sel_i[0])
      |=> o_status_word[asf_pkg::ASF_BIT_PRI_HI:asf_pkg::ASF_BIT_PRI_LO]
          == $past(wb_dat_i[asf_pkg::ASF_BIT_PRI_HI:asf_pkg::ASF_BIT_PRI_LO]);
  endproperty
  a_pri_write: assert property (p_pri_write) else $error("priority write lost");

  property p_ext_write;
    @(posedge i_ref_clk) disable iff (i_rst)
    (wr_req && wb_adr_i == asf_pkg::ASF_ADDR_CORE_CTRL && wb_sel_i[0])
      |=> ext_ff == $past(wb_dat_i[asf_pkg::ASF_BIT_EXT]);
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("extension write lost");

  property p_rpt;
    @(posedge i_ref_clk) disable iff (i_rst)
    ##1 o_status_word[asf_pkg::ASF_BIT_RPT] == $past(i_repeat_busy);
  endproperty
  a_rpt: assert property (p_rpt) else $error("repeat flag wrong");

  property p_neg;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_alu_valid && i_alu_update[asf_pkg::ASF_UPD_N])
      |=> o_status_word[asf_pkg::ASF_BIT_NEG] == $past(f_n);
  endproperty
  a_neg: assert property (p_neg) else $error("neg flag wrong");

  property p_carry;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_alu_valid && i_alu_update[asf_pkg::ASF_UPD_C])
      |=> o_status_word[asf_pkg::ASF_BIT_CARRY] == $past(f_c);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  property p_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_alu_valid && i_alu_update[asf_pkg::ASF_UPD_Z])
      |=> o_status_word[asf_pkg::ASF_BIT_ZERO] == $past(f_z);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    (!i_alu_valid && !(wb_cyc_i && wb_stb_i && wb_we_i))
      |=> o_status_word[asf_pkg::ASF_BIT_NEG:asf_pkg::ASF_BIT_CARRY]
          == $past(o_status_word[asf_pkg::ASF_BIT_NEG:asf_pkg::ASF_BIT_CARRY]);
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed idle");

  property p_ovf;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_alu_valid && i_alu_update[asf_pkg::ASF_UPD_OV])
      |=> o_status_word[asf_pkg::ASF_BIT_OVF] == $past(f_ov);
  endproperty
  a_ovf: assert property (p_ovf) else $error("ov flag wrong");

  property p_half;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_alu_valid && i_alu_update[asf_pkg::ASF_UPD_DC])
      |=> o_status_word[asf_pkg::ASF_BIT_HALF] == $past(f_dc);
  endproperty
  a_half: assert property (p_half) else $error("half carry flag wrong");

  // Unimplemented bits must never leak a software value
  property p_upper_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
    (o_status_word & ~asf_pkg::ASF_STATUS_RMASK) == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused status bits set");

  property p_ack_once;
    @(posedge i_ref_clk) disable iff (i_rst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");

  property p_ack_answer;
    @(posedge i_ref_clk) disable iff (i_rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  c_level15: cover property (@(posedge i_ref_clk) &o_priority_level);
  c_masked: cover property (@(posedge i_ref_clk) o_user_irq_masked);
  c_repeat: cover property (@(posedge i_ref_clk) o_status_word[asf_pkg::ASF_BIT_RPT]);
  c_ack: cover property (@(posedge i_ref_clk) wb_ack_o);
  c_collide: cover property (@(posedge i_ref_clk) wr_req && i_alu_valid);
endmodule
